/* File: hdl/probe_mux_regs.vh */
`ifndef PROBE_MUX_REGS_VH
`define PROBE_MUX_REGS_VH

// ****************************************
// register offsets on the serial port
// ****************************************
`define PROBE_CONFIG_ADDR     7'h04
`define OUTPUT_ROUTING_ADDR   7'h05
`define INTERNAL_STATUS_ADDR  7'h0E

// ****************************************
// serial frame layout
// ****************************************
`define CMD_READ_BIT          7
`define FRAME_CMD_LAST        5'h07
`define FRAME_DATA_LAST       5'h0F
`define FRAME_DONE            5'h10

// ****************************************
// field positions and reset values
// ****************************************
`define PROBE_SEL_LSB         0
`define GP1_SEL_LSB           0
`define GP2_SEL_LSB           4
`define PROBE_SEL_RST         3'h0
`define GP_SEL_RST            3'h0

// ****************************************
// clock and timing
// ****************************************
`define REF_CLK_HZ            10000000
`define OSC_SETTLE_NS         400
`define OSC_SETTLE_CYC        ((`OSC_SETTLE_NS * (`REF_CLK_HZ / 1000000) + 999) / 1000)
`define DIV_QUARTER_BIT       1
`define DIV_SIXTEENTH_BIT     3

`endif

/* File: hdl/xtal_clock_dividers.v */
`timescale 1ns/1ps
`include "probe_mux_regs.vh"

// free-running divider chain on the crystal clock
module xtal_clock_dividers (
	input  wire       ref_clk,        // crystal clock
	input  wire       arst_n,         // async reset, active low
	input  wire [2:0] ckdiv,          // clock output ratio select
	output wire       xtal_quarter,   // crystal clock / 4
	output wire       xtal_sixteenth, // crystal clock / 16
	output reg        ckout           // crystal clock / 2^(ckdiv+1)
);

	reg  [7:0] div_count;
	wire [7:0] next_div_count;

	assign next_div_count = div_count + 8'h01;

	// ****************************************
	// counter and taps
	// ****************************************
	// bits of a binary counter are clean divided clocks, no glitch from decode
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_count <= 8'h00;
			ckout     <= 1'b0;
		end else begin
			div_count <= next_div_count;
			ckout     <= next_div_count[ckdiv];
		end
	end

	assign xtal_quarter   = div_count[`DIV_QUARTER_BIT];
	assign xtal_sixteenth = div_count[`DIV_SIXTEENTH_BIT];

endmodule // xtal_clock_dividers

/* File: hdl/internal_status_probe_mux.v */
// Function
// - selector picks one of eight status groups
// - selector 0, bit 0 shows no-clock flag
// - selector 0, bit 1 shows crystal/4
// - selector 0, bit 2 shows crystal/16
// - selector 0, bit 3 shows clock output
// - internal enable is pin OR bit, selector 2
// - data and enable: soft bit OR pin
// - selector 3 shows tank code, divider kind
// - routing register at 0x05 selects both outputs
// - probe selector lives in register 0x04
// - selector 4 shows emulation code, amplifier-power-nonzero flag
// - selectors 5, 6 show integer and fraction
// - selector 7 shows lock and amplifier enable
// - divider kind reads 1 in fractional mode
`timescale 1ns/1ps
`include "probe_mux_regs.vh"

module internal_status_probe_mux (
	input  wire        ref_clk,              // crystal clock, 10 MHz
	input  wire        arst_n,               // async reset, active low
	input  wire        enable_pin,           // external enable pin
	input  wire        tx_bit_pin,           // external transmit data pin
	input  wire        spi_cs_n,             // serial chip select, active low
	input  wire        spi_sclk,             // serial clock from host
	input  wire        spi_sdi,              // serial data from host
	output wire        spi_sdo,              // serial data to host
	output wire        spi_sdo_oe,           // high while sdo is driven
	input  wire        osc_enable,           // crystal oscillator switched on
	input  wire        enable_soft,          // enable register bit
	input  wire        tx_bit_soft,          // transmit data register bit
	input  wire [2:0]  ckdiv,                // clock output ratio field
	input  wire [4:0]  tank_code_serial,     // serial-mode tank tuning code
	input  wire [4:0]  tank_code_emul,       // emulation-mode tank tuning code
	input  wire [4:0]  pa_power,             // amplifier power value
	input  wire [3:0]  synth_integer,        // divider integer word
	input  wire [11:0] synth_fraction,       // divider fractional word
	input  wire        frac_mode,            // synthesizer in fractional mode
	input  wire        pll_locked,           // synthesizer lock detect
	input  wire        pa_enable,            // amplifier enable flag
	output reg         internal_enable,      // combined enable
	output reg         tx_data,              // combined transmit data
	output reg         general_output_one,   // routed output one
	output reg         general_output_two,   // routed output two
	output wire        ckout,                // divided clock output
	output reg  [7:0]  internal_status,      // status register contents
	output wire [2:0]  probe_selector_field  // current probe selector
);

	// ****************************************
	// declarations
	// ****************************************
	localparam NUM_SYNC = 5;

	wire [NUM_SYNC-1:0] pin_raw;
	wire [NUM_SYNC-1:0] sync_out;
	wire                en_pin_s;
	wire                tx_pin_s;
	wire                cs_n_s;
	wire                sclk_s;
	wire                sdi_s;
	reg                 sclk_prev;
	wire                sclk_rise;

	wire                xtal_quarter;
	wire                xtal_sixteenth;

	reg  [2:0]          probe_sel;
	reg  [2:0]          gp1_sel;
	reg  [2:0]          gp2_sel;

	reg                 nock;
	reg  [7:0]          settle_count;
	wire                notover;
	reg  [7:0]          next_status;

	reg  [4:0]          bit_count;
	reg  [7:0]          shift_in;
	reg  [7:0]          shift_out;
	reg  [7:0]          cmd;
	reg                 rd_phase;
	wire [7:0]          frame_byte;
	wire                wr_strobe;

	// ****************************************
	// decode helpers
	// ****************************************
	// routing choices shared by both general outputs
	function route_pick;
		input [2:0] sel;
		input [7:0] src;
		begin
			route_pick = src[sel];
		end
	endfunction

	// register read map; unmapped offsets answer zero
	function [7:0] reg_read;
		input [6:0] addr;
		input [2:0] psel;
		input [2:0] g1;
		input [2:0] g2;
		input [7:0] stat;
		begin
			case (addr)
				`PROBE_CONFIG_ADDR:    reg_read = {5'h00, psel};
				`OUTPUT_ROUTING_ADDR:  reg_read = {1'b0, g2, 1'b0, g1};
				`INTERNAL_STATUS_ADDR: reg_read = stat;
				default:               reg_read = 8'h00;
			endcase
		end
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	assign pin_raw = {spi_sdi, spi_sclk, spi_cs_n, tx_bit_pin, enable_pin};

	// two flops per pin; the first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SYNC; gi = gi + 1) begin : g_sync
			reg stage_a;
			reg stage_b;
			// own flops per pin, so no vector bit has two driving processes
			always @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					stage_a <= (gi == 2) ? 1'b1 : 1'b0;
					stage_b <= (gi == 2) ? 1'b1 : 1'b0;
				end else begin
					stage_a <= pin_raw[gi];
					stage_b <= stage_a;
				end
			end
			assign sync_out[gi] = stage_b;
		end
	endgenerate

	assign en_pin_s = sync_out[0];
	assign tx_pin_s = sync_out[1];
	assign cs_n_s   = sync_out[2];
	assign sclk_s   = sync_out[3];
	assign sdi_s    = sync_out[4];

	// edge detect works on the settled copy only
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
		end
	end

	assign sclk_rise = sclk_s & ~sclk_prev;

	// ****************************************
	// crystal dividers
	// ****************************************
	xtal_clock_dividers u_dividers (
		.ref_clk        (ref_clk),
		.arst_n         (arst_n),
		.ckdiv          (ckdiv),
		.xtal_quarter   (xtal_quarter),
		.xtal_sixteenth (xtal_sixteenth),
		.ckout          (ckout)
	);

	// ****************************************
	// no-clock flag
	// ****************************************
	// flag holds high until the oscillator has run a settle interval
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			nock         <= 1'b1;
			settle_count <= 8'h00;
		end else if (!osc_enable) begin
			nock         <= 1'b1;
			settle_count <= 8'h00;
		end else if ({24'h000000, settle_count} == `OSC_SETTLE_CYC) begin
			nock         <= 1'b0;
		end else begin
			settle_count <= settle_count + 8'h01;
		end
	end

	// ****************************************
	// pin and bit combining
	// ****************************************
	// either source asserts; no priority between them
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			internal_enable <= 1'b0;
			tx_data         <= 1'b0;
		end else begin
			internal_enable <= en_pin_s | enable_soft;
			tx_data         <= tx_pin_s | tx_bit_soft;
		end
	end

	// ****************************************
	// status multiplexer
	// ****************************************
	assign notover = |pa_power;

	// group select; dashes in the map become zero
	always @* begin
		next_status = 8'h00;
		case (probe_sel)
			3'h0: next_status = {4'h0, ckout, xtal_sixteenth, xtal_quarter, nock};
			3'h1: next_status = 8'h00;
			3'h2: next_status = {4'h0, internal_enable, 3'h0};
			3'h3: next_status = {1'b0, frac_mode, 1'b0, tank_code_serial};
			3'h4: next_status = {2'h0, notover, tank_code_emul};
			3'h5: next_status = {synth_integer, synth_fraction[11:8]};
			3'h6: next_status = synth_fraction[7:0];
			3'h7: next_status = {6'h00, pll_locked, pa_enable};
			default: next_status = 8'h00;
		endcase
	end

	// sampled every edge so a read is at most one cycle stale
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			internal_status <= 8'h00;
		end else begin
			internal_status <= next_status;
		end
	end

	// ****************************************
	// serial register port
	// ****************************************
	// sclk is oversampled, so it must stay well below ref_clk / 8
	assign frame_byte = {shift_in[6:0], sdi_s};
	assign wr_strobe  = sclk_rise & ~cs_n_s & (bit_count == `FRAME_DATA_LAST) &
	                    ~cmd[`CMD_READ_BIT];

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_count <= 5'h00;
			shift_in  <= 8'h00;
			shift_out <= 8'h00;
			cmd       <= 8'h00;
			rd_phase  <= 1'b0;
		end else if (cs_n_s) begin
			bit_count <= 5'h00;
			rd_phase  <= 1'b0;
		end else if (sclk_rise && bit_count != `FRAME_DONE) begin
			shift_in  <= frame_byte;
			bit_count <= bit_count + 5'h01;
			if (bit_count == `FRAME_CMD_LAST) begin
				cmd <= frame_byte;
				if (frame_byte[`CMD_READ_BIT]) begin
					// load after the command so bit 7 is ready at the next sample
					shift_out <= reg_read(frame_byte[6:0], probe_sel, gp1_sel, gp2_sel, internal_status);
					rd_phase  <= 1'b1;
				end
			end else if (bit_count > `FRAME_CMD_LAST) begin
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

	assign spi_sdo    = shift_out[7];
	assign spi_sdo_oe = rd_phase;

	// ****************************************
	// configuration registers
	// ****************************************
	// bits not backed by a field are dropped on write and read as zero
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			probe_sel <= `PROBE_SEL_RST;
			gp1_sel   <= `GP_SEL_RST;
			gp2_sel   <= `GP_SEL_RST;
		end else if (wr_strobe) begin
			if (cmd[6:0] == `PROBE_CONFIG_ADDR) begin
				probe_sel <= frame_byte[`PROBE_SEL_LSB +: 3];
			end
			if (cmd[6:0] == `OUTPUT_ROUTING_ADDR) begin
				gp1_sel <= frame_byte[`GP1_SEL_LSB +: 3];
				gp2_sel <= frame_byte[`GP2_SEL_LSB +: 3];
			end
		end
	end

	assign probe_selector_field = probe_sel;

	// ****************************************
	// general output routing
	// ****************************************
	// same source list for both outputs keeps the map easy to remember
	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			general_output_one <= 1'b0;
			general_output_two <= 1'b0;
		end else begin
			general_output_one <= route_pick(gp1_sel, {tx_data, internal_enable, pa_enable,
				pll_locked, xtal_sixteenth, xtal_quarter, ckout, 1'b0});
			general_output_two <= route_pick(gp2_sel, {tx_data, internal_enable, pa_enable,
				pll_locked, xtal_sixteenth, xtal_quarter, ckout, 1'b0});
		end
	end

endmodule // internal_status_probe_mux

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps
// serial host: sclk idles low, msb first, ten ref_clk per bit
module spi_host_model (
	input  wire ref_clk,    // system clock
	input  wire spi_sdo,    // data from device
	input  wire spi_sdo_oe, // device drives sdo
	output reg  spi_cs_n,   // select, active low
	output reg  spi_sclk,   // serial clock
	output reg  spi_sdi     // data to device
);
	integer i;
	// idle levels at time zero
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_sdi = 1'b0;
	end
	task wait_clk(input integer n);
		repeat (n) @(negedge ref_clk);
	endtask
	// command byte then data byte; a released sdo reads low
	task frame(input [15:0] w, output [7:0] r);
		begin
			spi_cs_n = 1'b0;
			wait_clk(4);
			for (i = 15; i >= 0; i = i - 1) begin
				spi_sdi = w[i];
				wait_clk(5);
				if (i < 8) r[i] = spi_sdo & spi_sdo_oe;
				spi_sclk = 1'b1;
				wait_clk(5);
				spi_sclk = 1'b0;
			end
			wait_clk(6);
			spi_sdi = ~spi_sdi; // never rests on the last bit
			spi_cs_n = 1'b1;
			wait_clk(5); // gap well over the three-cycle minimum
		end
	endtask
endmodule // spi_host_model

/* File: testbench/status_probe_chk.sv */
`timescale 1ns/1ps
// watches the status mux and the combined enable and data
module status_probe_chk (
	input wire        ref_clk,              // system clock
	input wire        arst_n,               // async reset, active low
	input wire        enable_soft,          // enable register bit
	input wire        tx_bit_soft,          // data register bit
	input wire        osc_enable,           // oscillator on
	input wire        internal_enable,      // combined enable
	input wire        tx_data,              // combined data
	input wire        frac_mode,            // fractional divider mode
	input wire        pll_locked,           // lock detect
	input wire        pa_enable,            // amplifier enable
	input wire [2:0]  probe_selector_field, // probe selector
	input wire [7:0]  internal_status,      // status register
	input wire [3:0]  synth_integer,        // divider integer
	input wire [11:0] synth_fraction,       // divider fraction
	input wire [4:0]  tank_code_serial,     // serial tank code
	input wire [4:0]  tank_code_emul,       // emulation tank code
	input wire [4:0]  pa_power              // amplifier power
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// three cycles of margin let the no-clock flag settle
	sequence s_osc_off;
		(probe_selector_field == 3'h0 && !osc_enable) [*3];
	endsequence
	a_nock_shown: assert property (s_osc_off |=> internal_status[0]) else $error("no-clock flag missing");
	a_soft_enable: assert property (enable_soft |=> internal_enable) else $error("enable bit lost");
	a_soft_data: assert property (tx_bit_soft |=> tx_data) else $error("data bit lost");
	a_group_one: assert property (probe_selector_field == 3'h1 |=> internal_status == 8'h00)
		else $error("group 1 not zero");
	a_group_two: assert property (probe_selector_field == 3'h2 |=> internal_status == {4'h0, $past(internal_enable), 3'h0})
		else $error("group 2 wrong");
	a_group_tank: assert property (probe_selector_field == 3'h3 |=>
		internal_status == {1'b0, $past(frac_mode), 1'b0, $past(tank_code_serial)}) else $error("group 3 wrong");
	a_group_emul: assert property (probe_selector_field == 3'h4 |=>
		internal_status == {2'h0, |$past(pa_power), $past(tank_code_emul)}) else $error("group 4 wrong");
	a_group_int: assert property (probe_selector_field == 3'h5 |=>
		internal_status == {$past(synth_integer), $past(synth_fraction[11:8])}) else $error("group 5 wrong");
	a_group_frac: assert property (probe_selector_field == 3'h6 |=>
		internal_status == $past(synth_fraction[7:0])) else $error("group 6 wrong");
	a_group_lock: assert property (probe_selector_field == 3'h7 |=>
		internal_status == {6'h0, $past(pll_locked), $past(pa_enable)}) else $error("group 7 wrong");
endmodule // status_probe_chk
bind internal_status_probe_mux status_probe_chk chk (.*);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	reg ref_clk = 1'b0, arst_n = 1'b0, enable_pin = 1'b0, tx_bit_pin = 1'b0, osc_enable = 1'b0;
	reg enable_soft = 1'b0, tx_bit_soft = 1'b0, frac_mode = 1'b1, pll_locked = 1'b1, pa_enable = 1'b0;
	reg [2:0] ckdiv = 3'h0;
	reg [4:0] tank_code_serial = 5'h15, tank_code_emul = 5'h0A, pa_power = 5'h01;
	reg [3:0] synth_integer = 4'h9;
	reg [11:0] synth_fraction = 12'hA5C;
	wire spi_cs_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe, internal_enable, tx_data, ckout;
	wire general_output_one, general_output_two;
	wire [7:0] internal_status;
	wire [2:0] probe_selector_field;
	integer n_fail = 0, total_checks = 0, cycles = 0, k, t1, t2, t3, t4;
	reg [7:0] rd;
	reg ck_prev;
	internal_status_probe_mux uut (.*);
	spi_host_model host (.*);
	always #50 ref_clk = ~ref_clk;
	// hang guard, about 2.5 times the roughly 7900 cycles needed
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			summarize;
		end
	end
	task summarize;
		begin
			if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	task check8(input [7:0] got, input [7:0] want);
		begin
			total_checks = total_checks + 1;
			if (got !== want) begin
				n_fail = n_fail + 1;
				$display("ERROR %0t: got %h want %h", $time, got, want);
			end
		end
	endtask
	task wr(input [6:0] a, input [7:0] d);
		host.frame({1'b0, a, d}, rd);
	endtask
	task rdreg(input [6:0] a, input [7:0] want);
		begin
			host.frame({1'b1, a, 8'h00}, rd);
			check8(rd, want);
		end
	endtask
	// expected group contents from the present inputs
	function [7:0] grp(input [2:0] s);
		case (s)
			3'h1: grp = 8'h00;
			3'h2: grp = {4'h0, enable_pin | enable_soft, 3'h0};
			3'h3: grp = {1'b0, frac_mode, 1'b0, tank_code_serial};
			3'h4: grp = {2'h0, |pa_power, tank_code_emul};
			3'h5: grp = {synth_integer, synth_fraction[11:8]};
			3'h6: grp = synth_fraction[7:0];
			default: grp = {6'h0, pll_locked, pa_enable};
		endcase
	endfunction
	// main sequence on the falling edge
	initial begin
		repeat (8) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdreg(7'h04, 8'h00);
		rdreg(7'h05, 8'h00);
		rdreg(7'h30, 8'h00);
		// two passes over all selectors, flags flipped in the second
		for (k = 0; k < 16; k = k + 1) begin
			if (k == 8) begin
				{frac_mode, pll_locked, pa_enable, enable_soft, osc_enable} = 5'h07;
				pa_power = 5'h00;
			end
			wr(7'h04, {5'h00, k[2:0]});
			check8({5'h0, probe_selector_field}, {5'h00, k[2:0]});
			if (k[2:0] == 3'h0) check8(internal_status & 8'hF1, {7'h0, ~osc_enable});
			else rdreg(7'h0E, grp(k[2:0]));
		end
		// divider toggles over 32 cycles are exact whatever the phase
		wr(7'h04, 8'h00);
		for (k = 0; k < 2; k = k + 1) begin
			ckdiv = k ? 3'h2 : 3'h0;
			repeat (20) @(negedge ref_clk);
			t1 = 0;
			t2 = 0;
			t3 = 0;
			t4 = 0;
			rd = internal_status;
			ck_prev = ckout;
			repeat (32) begin
				@(negedge ref_clk);
				t1 = t1 + (internal_status[1] != rd[1]);
				t2 = t2 + (internal_status[2] != rd[2]);
				t3 = t3 + (internal_status[3] != rd[3]);
				t4 = t4 + (ckout != ck_prev);
				rd = internal_status;
				ck_prev = ckout;
			end
			check8(t1, 16);
			check8(t2, 4);
			check8(t3, k ? 8 : 32);
			check8(t4, k ? 8 : 32);
		end
		wr(7'h05, 8'hFF);
		rdreg(7'h05, 8'h77);
		wr(7'h05, 8'h76);
		for (k = 0; k < 4; k = k + 1) begin
			{enable_pin, enable_soft} = k[1:0];
			{tx_bit_pin, tx_bit_soft} = ~k[1:0];
			repeat (8) @(negedge ref_clk);
			check8({6'h0, internal_enable, tx_data}, {6'h0, |k[1:0], |(~k[1:0])});
			check8({6'h0, general_output_one, general_output_two}, {6'h0, |k[1:0], |(~k[1:0])});
		end
		wr(7'h05, 8'h00);
		check8({6'h0, general_output_one, general_output_two}, 8'h00);
		// clock taps routed out: /4 and ckout, then /16 and the low source
		for (k = 0; k < 2; k = k + 1) begin
			wr(7'h05, k ? 8'h03 : 8'h12);
			t1 = 0;
			t2 = 0;
			rd = {6'h0, general_output_one, general_output_two};
			repeat (32) begin
				@(negedge ref_clk);
				t1 = t1 + (general_output_one != rd[1]);
				t2 = t2 + (general_output_two != rd[0]);
				rd = {6'h0, general_output_one, general_output_two};
			end
			check8(t1, k ? 4 : 16);
			check8(t2, k ? 0 : 8);
		end
		// lock flag on one, amplifier enable on two, both polarities
		wr(7'h05, 8'h54);
		check8({6'h0, general_output_one, general_output_two}, {6'h0, pll_locked, pa_enable});
		{pll_locked, pa_enable} = 2'b10;
		repeat (4) @(negedge ref_clk);
		check8({6'h0, general_output_one, general_output_two}, 8'h02);
		// a reset in mid-run must bring both configuration registers back to zero
		wr(7'h04, 8'h05);
		arst_n = 1'b0;
		repeat (3) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		rdreg(7'h04, 8'h00);
		rdreg(7'h05, 8'h00);
		summarize;
	end
endmodule // tb_top
